// >>> rtl/pwm_pkg.sv
package pwm_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [4:0] OFS_CHAN_CTRL  = 5'h00;
    localparam logic [4:0] OFS_DUTY_LOW   = 5'h01;
    localparam logic [4:0] OFS_DUTY_HIGH  = 5'h02;
    localparam logic [4:0] OFS_TMR_SEL    = 5'h03;
    localparam logic [4:0] OFS_PERIOD0    = 5'h04;
    localparam logic [4:0] OFS_TCTRL0     = 5'h08;
    localparam logic [4:0] OFS_COUNT0     = 5'h0C;
    localparam logic [4:0] OFS_FLAGS      = 5'h10;
    localparam logic [4:0] OFS_PIN_CTRL   = 5'h11;

    // ************************************************************
    // field positions and codes
    // ************************************************************
    localparam int DC_LSB        = 4;
    localparam int RUN_BIT       = 2;
    localparam int DIR_BIT       = 0;
    localparam int LATCH_BIT     = 1;
    localparam logic [1:0] MODE_PWM_HI = 2'h3;
    localparam logic [1:0] PSC_1  = 2'h0;
    localparam logic [1:0] PSC_4  = 2'h1;
    localparam logic [1:0] PSC_16 = 2'h2;
    localparam int NUM_TIMERS    = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_PERIOD   = 8'hFF;
    localparam logic [7:0] RST_PIN_CTRL = 8'h01;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CLKS_PER_INSTR  = 4;
    localparam logic [1:0] QTR_LAST = 2'(CLKS_PER_INSTR - 1);

    // ************************************************************
    // types
    // ************************************************************
    typedef logic [7:0] byte_t;
    typedef logic [4:0] addr_t;

    typedef struct packed {
        addr_t addr;
        byte_t wdata;
        logic  wr;
        logic  rd;
    } reg_req_t;

    typedef struct packed {
        logic       run;
        logic [1:0] psc;
    } tctrl_t;

endpackage

// >>> rtl/standard_pwm_channel.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - period is (period+1) x 4 clocks x prescale
// - count equal to period clears on next increment
// - rollover sets pin unless duty is zero
// - rollover copies duty into active buffer
// - duty is low reg plus control bits 5:4
// - duty writes anytime, used from next period
// - active high reg read-only in modulation mode
// - time base is count plus quarter/prescale bits
// - time base equal to duty clears the pin
// - no match in period leaves pin unchanged
// - select field picks one of three timers
// - postscaler plays no part in the period
// - sleep freezes counting, state and pin level
// - reset restores registers, pin becomes input
// - cleared control register releases the pin
// - pin driven only with direction bit cleared
// - resolution is log2(4 x (period+1)) bits
// - all timing comes from the system clock
module standard_pwm_channel (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // register port
    input  wire pwm_pkg::reg_req_t req,
    output var  pwm_pkg::byte_t    rd_data,
    // power state
    input  wire logic              sleep,
    // channel output pin
    output logic                   pin_out,
    output logic                   pin_oe
);
    import pwm_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************

    // terminal prescaler count for each prescale code
    // code 3, the 1:64 divider, keeps the initial value of t
    function automatic logic [5:0] psc_top(input logic [1:0] code);
        logic [5:0] t;
        t = 6'h3F;
        if (code == PSC_1)
            t = 6'h00;
        else if (code == PSC_4)
            t = 6'h03;
        else if (code == PSC_16)
            t = 6'h0F;
        return t;
    endfunction

    // timer index from a register offset relative to a bank base
    function automatic logic [1:0] bank_idx(input addr_t a,
                                             input addr_t base);
        addr_t d;
        d = a - base;
        return d[1:0];
    endfunction

    // true if offset falls in the three-entry bank at base
    function automatic logic in_bank(input addr_t a,
                                     input addr_t base);
        return (a >= base) && (a < base + 5'(NUM_TIMERS));
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    // one count, prescaler and period per shared timer; only the
    // selected one drives this channel
    byte_t      chan_ctrl_q;
    byte_t      duty_low_q;
    byte_t      duty_hi_q;
    logic [1:0] duty_lsb_q;
    logic [1:0] tmr_sel_q;
    byte_t      period_q [NUM_TIMERS];
    tctrl_t     tctrl_q  [NUM_TIMERS];
    byte_t      count_q  [NUM_TIMERS];
    logic [5:0] psc_q    [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] flag_q;
    logic       dir_q;
    logic       latch_q;
    logic       pwm_out_q;
    logic [1:0] qtr_q;

    // ************************************************************
    // decode and timing
    // ************************************************************
    logic                  pwm_mode;
    logic                  released;
    logic                  tick;
    logic [NUM_TIMERS-1:0] inc;
    logic [NUM_TIMERS-1:0] roll;
    logic [1:0]            sel;
    logic [9:0]            time_base;
    logic [9:0]            duty_act;
    logic [9:0]            duty_next;
    logic                  sel_roll;
    logic                  duty_hit;

    // mode decode; only the upper two mode bits select modulation,
    // the other mode codes leave the pin to the port latch
    assign pwm_mode = (chan_ctrl_q[3:2] == MODE_PWM_HI);
    assign released = (chan_ctrl_q == RST_ZERO);

    // instruction tick every fourth clock; sleep stops it
    // a faster system clock gives a faster tick and a shorter period
    assign tick = (qtr_q == QTR_LAST) && !sleep;

    // unused select code falls back to the first timer
    assign sel = (tmr_sel_q < 2'(NUM_TIMERS)) ? tmr_sel_q : 2'h0;

    // next duty as software has written it
    assign duty_next = {duty_low_q,
                        chan_ctrl_q[DC_LSB+1:DC_LSB]};
    assign duty_act  = {duty_hi_q, duty_lsb_q};

    // time base against the buffered duty; the pin mux uses it directly
    // so the pulse ends in the matching cycle, not one clock late,
    // which would stretch every pulse by a clock
    assign duty_hit = (time_base == duty_act);

    // per-timer increment and rollover; postscaler never counts
    always_comb
    begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            inc[i]  = tick && tctrl_q[i].run
                      && (psc_q[i] == psc_top(tctrl_q[i].psc));
            roll[i] = inc[i] && (count_q[i] == period_q[i]);
        end
    end

    assign sel_roll = roll[sel];

    // low time base bits: quarter counter at 1:1, else prescaler
    // the bits taken are the top two of the prescaler's range, so one
    // time base step lasts the prescale factor in system clocks
    always_comb
    begin
        unique case (tctrl_q[sel].psc)
            PSC_1:   time_base = {count_q[sel], qtr_q};
            PSC_4:   time_base = {count_q[sel], psc_q[sel][1:0]};
            PSC_16:  time_base = {count_q[sel], psc_q[sel][3:2]};
            default: time_base = {count_q[sel], psc_q[sel][5:4]};
        endcase
    end

    // ************************************************************
    // quarter counter
    // ************************************************************

    // system-clock quarter counter, held in sleep
    // shared by all three timers, so their ticks always line up
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            qtr_q <= 2'h0;
        else if (!sleep)
            qtr_q <= qtr_q + 2'h1;
    end

    // ************************************************************
    // period timers
    // ************************************************************

    // prescaler and count; a count write also clears the prescaler
    // a stopped timer keeps count and prescaler, so a restart carries
    // on where it left off rather than at zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                count_q[i] <= RST_ZERO;
                psc_q[i]   <= 6'h00;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (req.wr && in_bank(req.addr, OFS_COUNT0)
                    && bank_idx(req.addr, OFS_COUNT0) == 2'(i))
                begin
                    count_q[i] <= req.wdata;
                    psc_q[i]   <= 6'h00;
                end
                else if (tick && tctrl_q[i].run)
                begin
                    if (inc[i])
                    begin
                        psc_q[i] <= 6'h00;
                        if (roll[i])
                            count_q[i] <= RST_ZERO;
                        else
                            count_q[i] <= count_q[i] + 8'h01;
                    end
                    else
                        psc_q[i] <= psc_q[i] + 6'h01;
                end
            end
        end
    end

    // period and timer control registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                period_q[i] <= RST_PERIOD;
                tctrl_q[i]  <= '0;
            end
        end
        else if (req.wr)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (in_bank(req.addr, OFS_PERIOD0)
                    && bank_idx(req.addr, OFS_PERIOD0) == 2'(i))
                    period_q[i] <= req.wdata;
                if (in_bank(req.addr, OFS_TCTRL0)
                    && bank_idx(req.addr, OFS_TCTRL0) == 2'(i))
                    tctrl_q[i] <= req.wdata[RUN_BIT:0];
            end
        end
    end

    // match flags: write one to clear, a new match wins
    // a clear that lands on a match edge is dropped on purpose, so
    // software never misses the end of a period
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            flag_q <= '0;
        else
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (roll[i])
                    flag_q[i] <= 1'b1;
                else if (req.wr && req.addr == OFS_FLAGS
                         && req.wdata[i])
                    flag_q[i] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // channel registers
    // ************************************************************

    // control, duty low, timer select and pin control
    // duty fields take writes at any time; the buffer below decides
    // when they reach the pin
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            chan_ctrl_q <= RST_ZERO;
            duty_low_q  <= RST_ZERO;
            tmr_sel_q   <= 2'h0;
            dir_q       <= RST_PIN_CTRL[DIR_BIT];
            latch_q     <= RST_PIN_CTRL[LATCH_BIT];
        end
        else if (req.wr)
        begin
            if (req.addr == OFS_CHAN_CTRL)
                chan_ctrl_q <= req.wdata;
            if (req.addr == OFS_DUTY_LOW)
                duty_low_q <= req.wdata;
            if (req.addr == OFS_TMR_SEL)
                tmr_sel_q <= req.wdata[1:0];
            if (req.addr == OFS_PIN_CTRL)
            begin
                dir_q   <= req.wdata[DIR_BIT];
                latch_q <= req.wdata[LATCH_BIT];
            end
        end
    end

    // active duty buffer: loaded at rollover, locked while modulating
    // both halves load on one edge, so a period never pairs new upper
    // bits with old lower bits
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            duty_hi_q  <= RST_ZERO;
            duty_lsb_q <= 2'h0;
        end
        else if (pwm_mode && sel_roll)
        begin
            duty_hi_q  <= duty_low_q;
            duty_lsb_q <= chan_ctrl_q[DC_LSB+1:DC_LSB];
        end
        else if (!pwm_mode && req.wr && req.addr == OFS_DUTY_HIGH)
            duty_hi_q <= req.wdata;
    end

    // ************************************************************
    // output generation
    // ************************************************************

    // set at rollover, cleared on match; no match keeps the level
    // leaving the modulation mode parks the latch low, so a later
    // return starts cleanly at the next rollover
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pwm_out_q <= 1'b0;
        else if (!pwm_mode)
            pwm_out_q <= 1'b0;
        else if (sel_roll)
            pwm_out_q <= (duty_next != 10'h000);
        else if (!sleep && duty_hit)
            pwm_out_q <= 1'b0;
    end

    // pin mux: port latch when released, direction gates the driver
    // the match gate reads registers only, so the pin moves only on
    // clock edges and holds still while sleep freezes the time base
    always_comb
    begin
        if (released)
            pin_out = latch_q;
        else if (pwm_mode)
            pin_out = pwm_out_q && !duty_hit;
        else
            pin_out = latch_q;
        pin_oe = !dir_q;
    end

    // ************************************************************
    // register read port
    // ************************************************************

    // read data registered, present only in the cycle after
    // reads have no side effects, so polling the flags is harmless
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rd_data <= RST_ZERO;
        else if (!req.rd)
            rd_data <= RST_ZERO;
        else if (in_bank(req.addr, OFS_PERIOD0))
            rd_data <= period_q[bank_idx(req.addr, OFS_PERIOD0)];
        else if (in_bank(req.addr, OFS_TCTRL0))
            rd_data <= {5'h00,
                        tctrl_q[bank_idx(req.addr, OFS_TCTRL0)]};
        else if (in_bank(req.addr, OFS_COUNT0))
            rd_data <= count_q[bank_idx(req.addr, OFS_COUNT0)];
        else
        begin
            unique case (req.addr)
                OFS_CHAN_CTRL: rd_data <= chan_ctrl_q;
                OFS_DUTY_LOW:  rd_data <= duty_low_q;
                OFS_DUTY_HIGH: rd_data <= duty_hi_q;
                OFS_TMR_SEL:   rd_data <= {6'h00, tmr_sel_q};
                OFS_FLAGS:     rd_data <= {5'h00, flag_q};
                OFS_PIN_CTRL:  rd_data <= {6'h00, latch_q, dir_q};
                default:       rd_data <= RST_ZERO;
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> test/pwm_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// port checks of the pwm channel
// ************************************
module pwm_chk
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst,
    // register port and power state
    input wire pwm_pkg::reg_req_t req,
    input wire pwm_pkg::byte_t    rd_data,
    input wire logic              sleep,
    // pin
    input wire logic              pin_out,
    input wire logic              pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // channel switched off, then the pin latch written
    sequence clr_ctrl;
        req.wr && req.addr == OFS_CHAN_CTRL && req.wdata == 8'h00;
    endsequence
    sequence set_pin;
        req.wr && req.addr == OFS_PIN_CTRL;
    endsequence

    rst_clean_a: assert property ($fell(rst) |->
        !pin_oe && !pin_out && rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    dir_ctrl_a: assert property (set_pin |=>
        pin_oe == !$past(req.wdata[DIR_BIT]))
        else $error("pin enable does not follow direction");
    dir_hold_a: assert property (!(req.wr && req.addr == OFS_PIN_CTRL)
        |=> $stable(pin_oe))
        else $error("pin enable moved without a write");
    sleep_pin_a: assert property (sleep && !req.wr |=> $stable(pin_out))
        else $error("pin level moved in sleep");
    pin_release_a: assert property (clr_ctrl ##1 set_pin |=>
        pin_out == $past(req.wdata[LATCH_BIT]))
        else $error("released pin does not show latch");
    port_hold_a: assert property (clr_ctrl ##1 set_pin ##1 !req.wr
        |=> $stable(pin_out))
        else $error("released pin still modulated");
    // read data stand only in the cycle after a read strobe
    idle_read_a: assert property (!req.rd |=> rd_data == 8'h00)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (req.rd && req.addr == 5'h1F |=>
        rd_data == 8'h00)
        else $error("unmapped offset read not zero");
endmodule

bind standard_pwm_channel pwm_chk i_pwm_chk (
    .ref_clk (ref_clk),
    .rst     (rst),
    .req     (req),
    .rd_data (rd_data),
    .sleep   (sleep),
    .pin_out (pin_out),
    .pin_oe  (pin_oe)
);
`default_nettype wire

// >>> test/tb_standard_pwm_channel.sv
`timescale 1ns/1ns
`default_nettype none
module tb_standard_pwm_channel;
    import pwm_pkg::*;
    logic     ref_clk     = 1'b0;
    logic     rst         = 1'b1;
    logic     sleep       = 1'b0;
    reg_req_t req         = '0;
    byte_t    rd_data;
    logic     pin_out;
    logic     pin_oe;
    int       n_errors    = 0;
    int       checks_done = 0;
    int       cyc         = 0;
    byte_t    v;
    addr_t    ra[8]       = '{OFS_CHAN_CTRL, OFS_DUTY_LOW, OFS_TMR_SEL,
        OFS_PERIOD0, 5'h05, 5'h06, OFS_PIN_CTRL, 5'h1F};
    byte_t    rv[8]       = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_PERIOD,
        RST_PERIOD, RST_PERIOD, RST_PIN_CTRL, RST_ZERO};

    standard_pwm_channel i_standard_pwm_channel (
        .ref_clk (ref_clk),
        .rst     (rst),
        .req     (req),
        .rd_data (rd_data),
        .sleep   (sleep),
        .pin_out (pin_out),
        .pin_oe  (pin_oe)
    );

    // ************************************
    // clock, hang guard, verdict
    // ************************************
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    // the whole run is near 400 cycles, so 6000 means a hang
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************
    // register port and pin tasks
    // ************************************
    task automatic chk(input byte_t seen, input byte_t exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write leaves the strobe up so writes can run back to back
    task automatic wr(input addr_t a, input byte_t d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
    endtask

    task automatic idle();
        req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input addr_t a, output byte_t d);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
        d = rd_data;
        @(posedge ref_clk);
    endtask

    task automatic pins(input byte_t exp);
        @(negedge ref_clk);
        chk({6'h00, pin_out, pin_oe}, exp);
        @(posedge ref_clk);
    endtask

    // counts high samples; a window of whole periods gives an exact figure
    task automatic hits(input int n, input byte_t exp);
        int h;
        h = 0;
        repeat (n)
        begin
            @(negedge ref_clk);
            h += int'(pin_out === 1'b1);
        end
        @(posedge ref_clk);
        chk(8'(h), exp);
    endtask

    task automatic pwm(input byte_t lo, input byte_t ct, input int n,
                       input byte_t exp);
        wr(OFS_DUTY_LOW, lo);
        wr(OFS_CHAN_CTRL, ct);
        idle();
        repeat (n) @(posedge ref_clk);
        hits(n, exp);
    endtask

    // ************************************
    // tests
    // ************************************
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        pins(8'h00);
        for (int i = 0; i < 8; i++)
        begin
            rd(ra[i], v);
            chk(v, rv[i]);
        end
        $display("reset values done");
        wr(OFS_PIN_CTRL, 8'h01);
        wr(OFS_TMR_SEL, 8'h00);
        wr(OFS_PERIOD0, 8'h00);
        wr(OFS_CHAN_CTRL, 8'h2C);
        wr(OFS_DUTY_LOW, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_TCTRL0, 8'h04);
        v = 8'h00;
        for (int i = 0; i < 20 && v[0] !== 1'b1; i++)
            rd(OFS_FLAGS, v);
        chk(v & 8'h01, 8'h01);
        wr(OFS_PIN_CTRL, 8'h00);
        pwm(8'h00, 8'h2C, 16, 8'h08);
        pwm(8'h00, 8'h1C, 16, 8'h04);
        pwm(8'h01, 8'h0C, 16, 8'h10);
        pwm(8'h00, 8'h0C, 16, 8'h00);
        $display("duty cases done");
        wr(OFS_PERIOD0, 8'h01);
        wr(OFS_TCTRL0, 8'h05);
        pwm(8'h01, 8'h0C, 64, 8'h20);
        $display("prescale done");
        wr(OFS_TCTRL0, 8'h00);
        wr(OFS_PERIOD0 + 5'h01, 8'h00);
        wr(OFS_TCTRL0 + 5'h01, 8'h04);
        wr(OFS_TMR_SEL, 8'h01);
        pwm(8'h00, 8'h2C, 16, 8'h08);
        $display("timer select done");
        sleep <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        v = {7'h00, pin_out};
        @(posedge ref_clk);
        hits(16, v[0] ? 8'h10 : 8'h00);
        sleep <= 1'b0;
        @(posedge ref_clk);
        hits(16, 8'h08);
        $display("sleep done");
        wr(OFS_DUTY_LOW, 8'h5A);
        repeat (4) idle();
        wr(OFS_TCTRL0 + 5'h01, 8'h00);
        rd(OFS_DUTY_HIGH, v);
        chk(v, 8'h5A);
        wr(OFS_DUTY_HIGH, 8'hAA);
        idle();
        rd(OFS_DUTY_HIGH, v);
        chk(v, 8'h5A);
        $display("read-only buffer done");
        wr(OFS_CHAN_CTRL, 8'h00);
        wr(OFS_PIN_CTRL, 8'h02);
        idle();
        pins(8'h03);
        wr(OFS_PIN_CTRL, 8'h03);
        idle();
        pins(8'h02);
        $display("pin release done");
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        pins(8'h00);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_PERIOD0 + 5'h01, v);
        chk(v, RST_PERIOD);
        $display("second reset done");
        summarize();
    end
endmodule
`default_nettype wire
